// >>> rrs_hold_timer.sv
// Purpose: hold duration timer counting sample ticks
// Assumes: dur in 0.1 s units, tick every 1 ms
// Notes:   a zero duration never raises busy
`timescale 1ns/1ps
`include "rrs_regs.svh"

module rrs_hold_timer (
   // clock and reset
   input  logic        clock,
   input  logic        nrst,
   // control
   input  logic        start,
   input  logic [15:0] dur,
   input  logic        tick,
   // status
   output logic        busy
);
   import rrs_pkg::*;

   rrs_timer_state_type t_q;
   rrs_timer_state_type t_d;

   // ==========================================================
   // countdown
   // ==========================================================
   always_comb begin
      t_d = t_q;
      if (start) begin
         t_d.cnt  = 16'(dur * `RRS_HOLD_UNIT_TICKS);
         t_d.busy = (dur != 16'h0000);
      end else if (tick && t_q.busy) begin
         t_d.cnt = t_q.cnt - 16'h0001;
         if (t_q.cnt == 16'h0001) begin
            t_d.busy = 1'b0;
         end
      end
   end

   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         t_q <= '0;
      end else begin
         t_q <= t_d;
      end
   end

   assign busy = t_q.busy;

   // ==========================================================
   // checks
   // ==========================================================
   default clocking cb @(posedge clock); endclocking
   default disable iff (!nrst);

   AST_TIMER_LOAD:
      assert property (start && dur != 16'h0000 |=>
                       busy && t_q.cnt == 16'($past(dur) * 100))
      else $error("hold timer did not load duration");
   AST_TIMER_END:
      assert property ($fell(t_q.busy) |-> $past(tick) && $past(t_q.cnt) == 16'h0001)
      else $error("hold timer released early");

endmodule : rrs_hold_timer

// >>> rrs_pkg.sv
// Purpose: types shared by the ramp controller files
// Assumes: nothing beyond the register header
// Notes:   all ramp and hold timer state lives in the structs below
package rrs_pkg;

   // ==========================================================
   // enumerations
   // ==========================================================
   typedef enum logic [1:0] {
      RRS_PH_IDLE  = 2'b00,
      RRS_PH_ACC   = 2'b01,
      RRS_PH_DEC   = 2'b10,
      RRS_PH_CONST = 2'b11
   } rrs_phase_type;

   typedef enum logic [1:0] {
      RRS_TRIG_TERM = 2'b00,
      RRS_TRIG_FREQ = 2'b01,
      RRS_TRIG_DIR  = 2'b10,
      RRS_TRIG_NONE = 2'b11
   } rrs_trig_type;

   // ==========================================================
   // state records
   // ==========================================================
   typedef struct packed {
      logic [1:0][9:0][31:0] set;
      logic [1:0]            ctrl;
      logic [15:0]           target;
      logic [6:0][7:0]       term_fn;
      logic [2:0][6:0]       term_sync;
      logic [6:0]            term;
      logic [2:0]            m2_sync;
      logic                  m2;
      logic                  pend;
      logic                  pwrite;
      logic                  pvalid;
      logic [7:0]            paddr;
      logic                  hready;
      logic                  hresp;
      logic [31:0]           hrdata;
      logic [15:0]           tick_cnt;
      logic                  tick;
      logic [15:0]           freq;
      logic                  dir;
      logic [15:0]           step_cnt;
      logic                  dir_cmd_prev;
      logic                  rev_toggle;
      logic                  use_b;
      logic                  fired_acc;
      logic                  fired_dec;
      logic                  hold;
      logic [15:0]           curve_start;
      logic                  curve_valid;
   } rrs_state_type;

   typedef struct packed {
      logic [15:0] cnt;
      logic        busy;
   } rrs_timer_state_type;

endpackage : rrs_pkg

// >>> rrs_ramp.sv
// Purpose: ramp rate switching and ramp hold for a drive frequency
// Assumes: one 40 MHz clock, ahb-lite register access
// Notes:   ramp time plus one is ticks per 0.01 Hz step, tick period 1 ms
//
// Local design decisions: the address map and the AHB-Lite slave port.
`timescale 1ns/1ps
`include "rrs_regs.svh"

module rrs_ramp #(
   parameter int TICK_CYCLES = `RRS_TICK_PERIOD_NS / `RRS_CLK_PERIOD_NS
) (
   // clock and reset
   input  logic        clock,
   input  logic        nrst,
   // ahb-lite slave
   input  logic        hsel,
   input  logic [31:0] haddr,
   input  logic [1:0]  htrans,
   input  logic        hwrite,
   input  logic [2:0]  hsize,
   input  logic [31:0] hwdata,
   input  logic        hready,
   output logic [31:0] hrdata,
   output logic        hreadyout,
   output logic        hresp,
   // input terminals
   input  logic [6:0]  term_in,
   input  logic        motor2_sel_in,
   // drive outputs
   output logic [15:0] out_freq,
   output logic        out_dir,
   output logic        ramp_set_b,
   output logic        ramp_hold
);
   import rrs_pkg::*;

   // ==========================================================
   // helpers
   // ==========================================================
   function automatic logic term_match(input logic [6:0]      lvl,
                                       input logic [6:0][7:0] fn,
                                       input logic [7:0]      code);
      logic hit;
      hit = 1'b0;
      for (int i = 0; i < 7; i++) begin
         if (lvl[i] && fn[i] == code) begin
            hit = 1'b1;
         end
      end
      return hit;
   endfunction : term_match

   function automatic logic [15:0] clamp16(input logic [15:0] v,
                                           input logic [15:0] lim);
      return (v > lim) ? lim : v;
   endfunction : clamp16

   function automatic rrs_state_type rst_state();
      rrs_state_type r;
      r = '0;
      for (int s = 0; s < 2; s++) begin
         r.set[s][`RRS_W_ACC_A] = `RRS_RST_RAMP;
         r.set[s][`RRS_W_DEC_A] = `RRS_RST_RAMP;
         r.set[s][`RRS_W_ACC_B] = `RRS_RST_RAMP;
         r.set[s][`RRS_W_DEC_B] = `RRS_RST_RAMP;
      end
      r.hready      = 1'b1;
      r.curve_valid = 1'b1;
      return r;
   endfunction : rst_state

   localparam rrs_state_type RST_STATE = rst_state();
   localparam logic [15:0]   TICK_LAST = 16'(TICK_CYCLES - 1);

   // ==========================================================
   // state and derived signals
   // ==========================================================
   rrs_state_type s_q;
   rrs_state_type s_d;

   logic          m;
   logic [31:0]   mode_w;
   rrs_trig_type  trig;
   logic [2:0]    acurve;
   logic [2:0]    dcurve;
   logic          two_stage;
   logic          hold_in_lvl;
   logic          timer_busy;
   logic          hold_eff;
   logic          run;
   logic          dir_cmd;
   logic [15:0]   tgt;
   rrs_phase_type phase;
   logic          rev_event;
   logic          use_b;
   logic [15:0]   rate;
   logic          ramp_go;
   logic          step_now;
   logic [15:0]   acc_hf;
   logic [15:0]   dec_hf;
   logic [31:0]   hold_w;
   logic          acc_start;
   logic          dec_start;
   logic          timer_start;
   logic [15:0]   timer_dur;
   logic          addr_ok;
   logic [3:0]    widx;

   // active parameter set
   assign m      = s_q.m2;
   assign mode_w = s_q.set[m][`RRS_W_MODE];
   assign trig   = rrs_trig_type'(mode_w[`RRS_MODE_TRIG_LSB +: 2]);
   assign acurve = mode_w[`RRS_MODE_ACURVE_LSB +: 3];
   assign dcurve = mode_w[`RRS_MODE_DCURVE_LSB +: 3];
   assign acc_hf = s_q.set[m][`RRS_W_ACC_HF][15:0];
   assign dec_hf = s_q.set[m][`RRS_W_DEC_HF][15:0];
   assign hold_w = s_q.set[m][`RRS_W_HOLD_T];

   // terminal functions
   assign two_stage   = term_match(s_q.term, s_q.term_fn, `RRS_FN_TWO_STAGE);
   assign hold_in_lvl = term_match(s_q.term, s_q.term_fn, `RRS_FN_HOLD);
   assign hold_eff    = timer_busy | hold_in_lvl;

   // target and phase
   assign run     = s_q.ctrl[`RRS_CTRL_RUN];
   assign dir_cmd = s_q.ctrl[`RRS_CTRL_REV];
   assign tgt     = (!run || dir_cmd != s_q.dir) ? 16'h0000 : s_q.target;

   always_comb begin
      if (s_q.freq < tgt) begin
         phase = RRS_PH_ACC;
      end else if (s_q.freq > tgt) begin
         phase = RRS_PH_DEC;
      end else if (s_q.freq == 16'h0000) begin
         phase = RRS_PH_IDLE;
      end else begin
         phase = RRS_PH_CONST;
      end
   end

   // ramp set selection
   assign rev_event = run && dir_cmd != s_q.dir_cmd_prev && s_q.freq != 16'h0000;

   always_comb begin
      case (trig)
         RRS_TRIG_TERM: begin
            use_b = two_stage;
         end
         RRS_TRIG_FREQ: begin
            if (phase == RRS_PH_DEC) begin
               use_b = s_q.freq >= s_q.set[m][`RRS_W_DEC_SW][15:0];
            end else begin
               use_b = s_q.freq >= s_q.set[m][`RRS_W_ACC_SW][15:0];
            end
         end
         RRS_TRIG_DIR: begin
            use_b = s_q.rev_toggle;
         end
         default: begin
            use_b = 1'b0;
         end
      endcase
   end

   always_comb begin
      if (phase == RRS_PH_DEC) begin
         rate = use_b ? s_q.set[m][`RRS_W_DEC_B][15:0]
                      : s_q.set[m][`RRS_W_DEC_A][15:0];
      end else begin
         rate = use_b ? s_q.set[m][`RRS_W_ACC_B][15:0]
                      : s_q.set[m][`RRS_W_ACC_A][15:0];
      end
   end

   // stepping and automatic hold
   assign ramp_go  = s_q.tick && !hold_eff &&
                     (phase == RRS_PH_ACC || phase == RRS_PH_DEC);
   assign step_now = ramp_go && s_q.step_cnt >= rate;

   assign acc_start = step_now && phase == RRS_PH_ACC && !s_q.fired_acc &&
                      s_q.freq + 16'h0001 == acc_hf;
   assign dec_start = step_now && phase == RRS_PH_DEC && !s_q.fired_dec &&
                      s_q.freq - 16'h0001 == dec_hf;
   assign timer_start = acc_start | dec_start;
   assign timer_dur   = acc_start ? hold_w[15:0]
                                  : hold_w[`RRS_HOLDT_DEC_LSB +: 16];

   rrs_hold_timer u_timer (
      .clock (clock),
      .nrst  (nrst),
      .start (timer_start),
      .dur   (timer_dur),
      .tick  (s_q.tick),
      .busy  (timer_busy)
   );

   // bus
   assign addr_ok = hsel && htrans[1] && hready;
   assign widx    = s_q.paddr[5:2];

   // ==========================================================
   // next state
   // ==========================================================
   always_comb begin
      s_d = s_q;

      // three-stage input synchronisers
      s_d.term_sync = {s_q.term_sync[1], s_q.term_sync[0], term_in};
      s_d.term      = (s_q.term_sync[1] & s_q.term_sync[2]) |
                      (s_q.term & (s_q.term_sync[1] | s_q.term_sync[2]));
      s_d.m2_sync   = {s_q.m2_sync[1:0], motor2_sel_in};
      if (s_q.m2_sync[1] == s_q.m2_sync[2]) begin
         s_d.m2 = s_q.m2_sync[2];
      end

      // sample tick
      if (s_q.tick_cnt >= TICK_LAST) begin
         s_d.tick_cnt = 16'h0000;
         s_d.tick     = 1'b1;
      end else begin
         s_d.tick_cnt = s_q.tick_cnt + 16'h0001;
         s_d.tick     = 1'b0;
      end

      // ahb-lite slave, one wait state
      if (s_q.pend) begin
         s_d.pend   = 1'b0;
         s_d.hready = 1'b1;
         if (s_q.pwrite) begin
            if (s_q.pvalid && !s_q.paddr[7] && widx < `RRS_SET_WORDS) begin
               case (widx)
                  `RRS_W_ACC_SW, `RRS_W_DEC_SW,
                  `RRS_W_ACC_HF, `RRS_W_DEC_HF: begin
                     s_d.set[s_q.paddr[6]][widx] =
                        {16'h0000, clamp16(hwdata[15:0], `RRS_FREQ_MAX)};
                  end
                  `RRS_W_HOLD_T: begin
                     s_d.set[s_q.paddr[6]][widx] =
                        {clamp16(hwdata[31:16], `RRS_HOLDT_MAX),
                         clamp16(hwdata[15:0], `RRS_HOLDT_MAX)};
                  end
                  default: begin
                     s_d.set[s_q.paddr[6]][widx] = hwdata;
                  end
               endcase
            end else if (s_q.pvalid) begin
               case (s_q.paddr)
                  `RRS_OFS_CTRL: begin
                     s_d.ctrl = hwdata[1:0];
                  end
                  `RRS_OFS_TARGET: begin
                     s_d.target = clamp16(hwdata[15:0], `RRS_FREQ_MAX);
                  end
                  `RRS_OFS_TERM_LO: begin
                     s_d.term_fn[3:0] = hwdata;
                  end
                  `RRS_OFS_TERM_HI: begin
                     s_d.term_fn[6:4] = hwdata[23:0];
                  end
                  default: begin
                  end
               endcase
            end
         end else begin
            s_d.hrdata = 32'h00000000;
            if (s_q.pvalid && !s_q.paddr[7] && widx < `RRS_SET_WORDS) begin
               s_d.hrdata = s_q.set[s_q.paddr[6]][widx];
            end else if (s_q.pvalid) begin
               case (s_q.paddr)
                  `RRS_OFS_CTRL: begin
                     s_d.hrdata = {30'h00000000, s_q.ctrl};
                  end
                  `RRS_OFS_TARGET: begin
                     s_d.hrdata = {16'h0000, s_q.target};
                  end
                  `RRS_OFS_TERM_LO: begin
                     s_d.hrdata = s_q.term_fn[3:0];
                  end
                  `RRS_OFS_TERM_HI: begin
                     s_d.hrdata = {8'h00, s_q.term_fn[6:4]};
                  end
                  `RRS_OFS_FREQ: begin
                     s_d.hrdata = {s_q.curve_start, s_q.freq};
                  end
                  `RRS_OFS_STAT: begin
                     s_d.hrdata = {8'h00, 1'b0, s_q.term, 7'h00,
                                   s_q.curve_valid, s_q.m2, hold_in_lvl,
                                   timer_busy, s_q.hold, s_q.use_b,
                                   s_q.dir, phase};
                  end
                  default: begin
                  end
               endcase
            end
         end
      end else if (addr_ok) begin
         s_d.pend   = 1'b1;
         s_d.hready = 1'b0;
         s_d.pwrite = hwrite;
         s_d.paddr  = haddr[7:0];
         s_d.pvalid = haddr[31:8] == 24'h000000 && hsize == 3'b010 &&
                      haddr[1:0] == 2'b00;
      end

      // direction taken only at standstill
      if (s_q.freq == 16'h0000 && run) begin
         s_d.dir = dir_cmd;
      end
      s_d.dir_cmd_prev = dir_cmd;
      s_d.rev_toggle   = s_q.rev_toggle ^ rev_event;
      s_d.use_b        = use_b;

      // ramp stepping, frozen by hold
      if (step_now) begin
         s_d.step_cnt = 16'h0000;
         if (phase == RRS_PH_ACC) begin
            s_d.freq = s_q.freq + 16'h0001;
         end else begin
            s_d.freq = s_q.freq - 16'h0001;
         end
      end else if (ramp_go) begin
         s_d.step_cnt = s_q.step_cnt + 16'h0001;
      end else if (!hold_eff) begin
         s_d.step_cnt = (phase == RRS_PH_ACC || phase == RRS_PH_DEC)
                        ? s_q.step_cnt : 16'h0000;
      end

      // one automatic hold per segment
      if (phase != RRS_PH_ACC) begin
         s_d.fired_acc = 1'b0;
      end
      if (phase != RRS_PH_DEC) begin
         s_d.fired_dec = 1'b0;
      end
      if (acc_start) begin
         s_d.fired_acc = 1'b1;
      end
      if (dec_start) begin
         s_d.fired_dec = 1'b1;
      end

      // curve progress around a hold
      s_d.hold = hold_eff;
      if (hold_eff && !s_q.hold) begin
         if ((phase == RRS_PH_DEC ? dcurve : acurve) != `RRS_CURVE_LINEAR) begin
            s_d.curve_valid = 1'b0;
         end
      end else if (!hold_eff && s_q.hold) begin
         s_d.curve_start = s_q.freq;
         s_d.curve_valid = 1'b1;
      end
   end

   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         s_q <= RST_STATE;
      end else begin
         s_q <= s_d;
      end
   end

   // ==========================================================
   // outputs
   // ==========================================================
   assign hrdata     = s_q.hrdata;
   assign hreadyout  = s_q.hready;
   assign hresp      = s_q.hresp;
   assign out_freq   = s_q.freq;
   assign out_dir    = s_q.dir;
   assign ramp_set_b = s_q.use_b;
   assign ramp_hold  = s_q.hold;

   // ==========================================================
   // checks
   // ==========================================================
   default clocking cb @(posedge clock); endclocking
   default disable iff (!nrst);

   sequence s_addr_taken;
      hsel && htrans[1] && hready && !s_q.pend;
   endsequence
   sequence s_one_wait;
      !hreadyout ##1 hreadyout;
   endsequence
   sequence s_hold_fall;
      s_q.hold && !hold_eff;
   endsequence

   AST_BUS_ONE_WAIT:
      assert property (s_addr_taken |=> s_one_wait)
      else $error("bus answer not after one wait state");
   AST_FREEZE:
      assert property (hold_eff |=> s_q.freq == $past(s_q.freq))
      else $error("frequency moved during hold");
   AST_TRIG_TERM:
      assert property (trig == RRS_TRIG_TERM |=> s_q.use_b == $past(two_stage))
      else $error("two-stage input not followed");
   AST_TRIG_FREQ:
      assert property (trig == RRS_TRIG_FREQ && phase == RRS_PH_ACC &&
                       s_q.freq < s_q.set[m][`RRS_W_ACC_SW][15:0] |=> !s_q.use_b)
      else $error("second rate used below transition");
   AST_TRIG_DIR:
      assert property (rev_event && trig == RRS_TRIG_DIR ##1 trig == RRS_TRIG_DIR
                       |=> s_q.use_b != $past(s_q.use_b))
      else $error("reversal did not swap ramp set");
   AST_HOLD_IN:
      assert property (hold_in_lvl |=> s_q.hold ##0 s_q.freq == $past(s_q.freq))
      else $error("hold input did not pause ramp");
   AST_HOLD_OR:
      assert property (!hold_in_lvl && !timer_busy |=> !s_q.hold)
      else $error("hold stayed without a cause");
   AST_AUTO_START:
      assert property (acc_start && hold_w[15:0] != 16'h0000 |=> timer_busy [*2])
      else $error("accel hold did not start");
   AST_AUTO_ONCE:
      assert property (s_q.fired_acc && phase == RRS_PH_ACC |-> !acc_start)
      else $error("second automatic hold in segment");
   AST_HOLD_LIMIT:
      assert property (s_q.set[m][`RRS_W_ACC_HF][15:0] <= `RRS_FREQ_MAX &&
                       hold_w[15:0] <= `RRS_HOLDT_MAX)
      else $error("hold setting beyond range");
   AST_CURVE_CLR:
      assert property (hold_eff && !s_q.hold && phase == RRS_PH_ACC &&
                       acurve != `RRS_CURVE_LINEAR |=> !s_q.curve_valid)
      else $error("curve progress kept across hold");
   AST_CURVE_RESUME:
      assert property (s_hold_fall |=> s_q.curve_valid &&
                       s_q.curve_start == $past(s_q.freq))
      else $error("curve not restarted from held frequency");

endmodule : rrs_ramp

// >>> rrs_regs.svh
// Purpose: register map, field positions, reset values and timing
// Assumes: 32-bit ahb-lite words, one aligned word per register
// Notes:   frequency in 0.01 Hz, hold time in 0.1 s, ramp time in ticks
`ifndef RRS_REGS_SVH
`define RRS_REGS_SVH

// ==========================================================
// map: set words at base + 4 * index, set 2 at 0x40
// ==========================================================
`define RRS_SET2_BASE       8'h40
`define RRS_SET_WORDS       4'hA
`define RRS_W_ACC_A         4'h0
`define RRS_W_DEC_A         4'h1
`define RRS_W_ACC_B         4'h2
`define RRS_W_DEC_B         4'h3
`define RRS_W_MODE          4'h4
`define RRS_W_ACC_SW        4'h5
`define RRS_W_DEC_SW        4'h6
`define RRS_W_ACC_HF        4'h7
`define RRS_W_DEC_HF        4'h8
`define RRS_W_HOLD_T        4'h9
`define RRS_OFS_CTRL        8'h80
`define RRS_OFS_TARGET      8'h84
`define RRS_OFS_TERM_LO     8'h88
`define RRS_OFS_TERM_HI     8'h8C
`define RRS_OFS_FREQ        8'h90
`define RRS_OFS_STAT        8'h94

// ==========================================================
// field positions
// ==========================================================
`define RRS_CTRL_RUN        0
`define RRS_CTRL_REV        1
`define RRS_MODE_TRIG_LSB   0
`define RRS_MODE_ACURVE_LSB 8
`define RRS_MODE_DCURVE_LSB 16
`define RRS_HOLDT_DEC_LSB   16

// ==========================================================
// limits, reset values, codes
// ==========================================================
`define RRS_FREQ_MAX        16'hE678
`define RRS_HOLDT_MAX       16'h0258
`define RRS_RST_RAMP        32'h0000000A
`define RRS_FN_TWO_STAGE    8'h09
`define RRS_FN_HOLD         8'h53
`define RRS_CURVE_LINEAR    3'h0

// ==========================================================
// timing
// ==========================================================
`define RRS_CLK_PERIOD_NS   25
`define RRS_TICK_PERIOD_NS  1000000
`define RRS_HOLD_UNIT_TICKS 100

`endif

// >>> rrs_term_model.sv
// Purpose: far-side model of the input terminal pins
// Assumes: levels are commanded by the bench
// Notes:   pins move only just after a rising edge
`timescale 1ns/1ps
module rrs_term_model (
   // clock
   input  wire logic       clock,
   // command
   input  wire logic [6:0] lvl,
   input  wire logic       m2,
   // pins
   output logic      [6:0] term_in,
   output logic            motor2_sel_in
);
   always @(posedge clock) begin
      term_in       <= lvl;
      motor2_sel_in <= m2;
   end
endmodule : rrs_term_model

// >>> tb.sv
// Purpose: bench for the ramp controller over ahb-lite
// Assumes: short tick of 4 clocks
// Notes:   terminal 0 two-stage, terminal 1 hold
`timescale 1ns/1ps
module tb;
   logic        clock = 0, nrst = 0, hwrite = 0;
   logic [1:0]  htrans = 2'h0;
   logic [2:0]  hsize = 3'h2;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, r;
   logic        hreadyout, hresp, m2 = 0, out_dir, ramp_set_b, ramp_hold;
   logic [6:0]  lvl = 7'h00, term_in;
   logic        motor2_sel_in;
   logic [15:0] out_freq, f;
   int          num_errors = 0, total_checks = 0, cyc = 0;
   rrs_term_model i_term (.clock(clock), .lvl(lvl), .m2(m2), .term_in(term_in),
                          .motor2_sel_in(motor2_sel_in));
   rrs_ramp #(.TICK_CYCLES(4)) i_dut (.clock(clock), .nrst(nrst), .hsel(1'b1),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
      .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
      .hresp(hresp), .term_in(term_in), .motor2_sel_in(motor2_sel_in),
      .out_freq(out_freq), .out_dir(out_dir), .ramp_set_b(ramp_set_b),
      .ramp_hold(ramp_hold));
   // ==========================================================
   // helpers
   // ==========================================================
   initial begin
      forever #12.5 clock = ~clock;
   end
   task conclude;
      $display("errors %0d checks %0d", num_errors, total_checks);
      if (num_errors == 0 && total_checks > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : conclude
   always @(posedge clock) begin
      cyc <= cyc + 1;
      if (cyc == 30000) begin
         num_errors++;
         conclude();
      end
   end
   task chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task bus(input logic [31:0] a, input logic w, input logic [31:0] d);
      @(posedge clock);
      haddr  <= a;
      htrans <= 2'h2;
      hwrite <= w;
      do @(posedge clock); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge clock); while (hreadyout !== 1'b1);
      r = hrdata;
   endtask : bus
   task rd(input logic [31:0] a, input logic [31:0] exp);
      bus(a, 1'b0, 32'h0);
      chk(r, exp);
      chk(hresp, 1'b0);
   endtask : rd
   task wt(input int n);
      repeat (n) @(posedge clock);
   endtask : wt
   // ==========================================================
   // tests
   // ==========================================================
   initial begin
      wt(8);
      nrst <= 1'b1;
      rd(32'h08, 32'h0000000A);
      rd(32'h4C, 32'h0000000A);
      rd(32'h10, 32'h00000000);
      rd(32'hFC, 32'h00000000);
      bus(32'h14, 1'b1, 32'h0000FFFF);
      rd(32'h14, 32'h0000E678);
      bus(32'h24, 1'b1, 32'hFFFFFFFF);
      rd(32'h24, 32'h02580258);
      bus(32'h50, 1'b1, 32'h00000002);
      rd(32'h50, 32'h00000002);
      bus(32'h00, 1'b1, 32'h0);
      bus(32'h88, 1'b1, 32'h00005309);
      bus(32'h84, 1'b1, 32'd1000);
      bus(32'h80, 1'b1, 32'h1);
      wt(20);
      lvl <= 7'h01;
      wt(10);
      chk(ramp_set_b, 1'b1);
      lvl <= 7'h02;
      wt(10);
      chk(ramp_set_b, 1'b0);
      chk(ramp_hold, 1'b1);
      f = out_freq;
      wt(40);
      chk(out_freq, f);
      lvl <= 7'h00;
      wt(20);
      chk(ramp_hold, 1'b0);
      chk(out_freq > f, 1'b1);
      bus(32'h10, 1'b1, 32'h1);
      bus(32'h14, 1'b1, 32'h0);
      wt(10);
      chk(ramp_set_b, 1'b1);
      bus(32'h10, 1'b1, 32'h00000100);
      bus(32'h24, 1'b1, 32'h00000001);
      f = out_freq + 16'h0014;
      bus(32'h1C, 1'b1, {16'h0000, f});
      wt(100);
      chk(ramp_hold, 1'b1);
      chk(out_freq, f);
      bus(32'h94, 1'b0, 32'h0);
      chk(r & 32'h00000100, 32'h0);
      wt(420);
      chk(ramp_hold, 1'b0);
      bus(32'h90, 1'b0, 32'h0);
      chk(r[31:16], f);
      m2 <= 1'b1;
      wt(10);
      rd(32'h94, 32'h00000181);
      bus(32'h80, 1'b1, 32'h00000003);
      wt(4);
      chk(ramp_set_b, 1'b1);
      chk(out_dir, 1'b0);
      conclude();
   end
endmodule : tb
